//--- agr_regs.sv
// Read-only attitude, covariance, temperature and GPS output register bank
`timescale 1ns/1ps
`default_nettype none
`include "agr_map.svh"

// How it works
// - Processed Z field is raw minus offsets, times the calibration row.
// - Processed Z sits in the upper half of its word, lower half zero.
// - One processed field count is 0.000305176 of a unit-norm field.
// - Roll is the upper half and pitch the lower half of word 0x62.
// - Yaw is the upper half of word 0x63, lower half zero.
// - Euler words update in both modes, from each attitude update.
// - Quaternion a/b sit in word 0x64 and c/d in word 0x65.
// - Quaternion words only take updates while quaternion mode is on.
// - Sixteen covariance floats sit row-major at 0x66 to 0x75.
// - In Euler mode only the first three rows and columns take new data; updates to the rest store zero.
// - Word 0x76 holds gyro temperature, also fed to compensation.
// - With GPS, longitude, latitude and altitude sit at 0x77 to 0x79.
// - With GPS, north, east and height from home sit at 0x7a to 0x7c.
// - Word 0x7d holds course in the upper and speed in the lower half.
// - Course is a signed count of hundredths of a degree.
// - Speed is an unsigned count of hundredths of a metre per second.
module agr_regs (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // Mode and presence levels
    input  wire logic                 quat_mode,
    input  wire logic                 gps_present,
    // Estimator and sensor updates
    input  wire agr_pkg::agr_mag_in_t  mag_in,
    input  wire agr_pkg::agr_att_in_t  att_in,
    input  wire agr_pkg::agr_cov_in_t  cov_in,
    input  wire agr_pkg::agr_word_in_t temp_in,
    // GPS updates
    input  wire agr_pkg::agr_trio_in_t pos_in,
    input  wire agr_pkg::agr_trio_in_t rel_in,
    input  wire agr_pkg::agr_vtg_in_t  vtg_in,
    // Register read port
    input  wire agr_pkg::agr_rd_req_t  rd_req,
    output agr_pkg::agr_rd_rsp_t      rd_rsp,
    // Temperature to gyro compensation
    output logic [31:0]               gyro_temp
);
    import agr_pkg::*;

    agr_magz_t magz;
    agr_bank_t s_ff;
    agr_bank_t nxt;

    // -------------------------------------------------------------
    // Decoding helpers
    // -------------------------------------------------------------

    // Address belongs to this bank
    function automatic logic agr_hit(input logic [7:0] a);
        agr_hit = (a >= `AGR_OFS_MAGZ) && (a <= `AGR_OFS_CRS_SPD);
    endfunction

    // Covariance cell carries data in the current mode
    function automatic logic agr_cov_keep(
        input logic       qm,
        input logic [3:0] idx
    );
        agr_cov_keep = qm || ((idx[1:0] != 2'h3) && (idx[3:2] != 2'h3));
    endfunction

    // Word selection for a read
    function automatic logic [31:0] agr_read(
        input agr_bank_t  b,
        input logic [7:0] a
    );
        logic [7:0] ofs;
        ofs = a - `AGR_OFS_COV_FIRST;
        agr_read = `AGR_WORD_RST;
        case (a)
            `AGR_OFS_MAGZ:     agr_read = b.magz;
            `AGR_OFS_EULER_RP: agr_read = b.euler_rp;
            `AGR_OFS_YAW:      agr_read = b.yaw;
            `AGR_OFS_QUAT_AB:  agr_read = b.quat_ab;
            `AGR_OFS_QUAT_CD:  agr_read = b.quat_cd;
            `AGR_OFS_TEMP:     agr_read = b.temp;
            `AGR_OFS_LON:      agr_read = b.lon;
            `AGR_OFS_LAT:      agr_read = b.lat;
            `AGR_OFS_ALT:      agr_read = b.alt;
            `AGR_OFS_REL_N:    agr_read = b.rel_n;
            `AGR_OFS_REL_E:    agr_read = b.rel_e;
            `AGR_OFS_REL_H:    agr_read = b.rel_h;
            `AGR_OFS_CRS_SPD:  agr_read = b.crs_spd;
            default: begin
                // row-major cells, four addresses per row
                if ((a >= `AGR_OFS_COV_FIRST) &&
                    (a <= `AGR_OFS_COV_LAST)) begin
                    agr_read = b.cov[ofs[3:0]];
                end
            end
        endcase
    endfunction

    // -------------------------------------------------------------
    // Processed Z calculator
    // -------------------------------------------------------------
    agr_magz u_magz (
        .clk      (clk),
        .rst      (rst),
        .mag_in   (mag_in),
        .magz_out (magz)
    );

    // -------------------------------------------------------------
    // Next state of the bank
    // -------------------------------------------------------------
    // Each word is built whole here, so a read never sees half of it
    always_comb begin
        nxt          = s_ff;
        nxt.rsp.ack  = 1'b0;
        nxt.rsp.miss = 1'b0;
        if (magz.vld) begin
            nxt.magz = {magz.val, `AGR_RESV_HALF};
        end
        // Euler words follow every attitude update
        if (att_in.vld) begin
            nxt.euler_rp = {att_in.roll, att_in.pitch};
            nxt.yaw = {att_in.yaw, `AGR_RESV_HALF};
            if (quat_mode) begin
                // a/b then c/d, first of each pair high
                nxt.quat_ab = {att_in.qa, att_in.qb};
                nxt.quat_cd = {att_in.qc, att_in.qd};
            end
        end
        // unused row and column forced to zero
        if (cov_in.vld) begin
            if (agr_cov_keep(quat_mode, cov_in.idx)) begin
                nxt.cov[cov_in.idx] = cov_in.val;
            end else begin
                nxt.cov[cov_in.idx] = `AGR_WORD_RST;
            end
        end
        if (temp_in.vld) begin
            nxt.temp = temp_in.val;
        end
        // absolute position only with a receiver
        if (gps_present && pos_in.vld) begin
            nxt.lon = pos_in.a;
            nxt.lat = pos_in.b;
            nxt.alt = pos_in.c;
        end
        if (gps_present && rel_in.vld) begin
            nxt.rel_n = rel_in.a;
            nxt.rel_e = rel_in.b;
            nxt.rel_h = rel_in.c;
        end
        if (gps_present && vtg_in.vld) begin
            nxt.crs_spd[`AGR_HI_MSB:`AGR_HI_LSB] = vtg_in.course;
            // unsigned hundredths of a metre per second
            nxt.crs_spd[`AGR_LO_MSB:`AGR_LO_LSB] = vtg_in.speed;
        end
        // reads sample the settled bank, never this cycle's update
        if (rd_req.en) begin
            nxt.rsp.ack  = 1'b1;
            nxt.rsp.miss = !agr_hit(rd_req.addr);
            nxt.rsp.data = agr_read(s_ff, rd_req.addr);
        end
    end

    // -------------------------------------------------------------
    // State register
    // -------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt;
        end
    end

    // Outputs straight from the state
    assign rd_rsp    = s_ff.rsp;
    assign gyro_temp = s_ff.temp;

    // -------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------

    property p_magz_word;
        @(posedge clk) disable iff (rst)
        mag_in.vld |=> ##1
            (s_ff.magz[31:16] == $past(magz.val)) &&
            (s_ff.magz[15:0] == `AGR_RESV_HALF);
    endproperty
    a_magz_word: assert property (p_magz_word)
        else $error("processed z word not packed two cycles on");

    property p_euler_pack;
        @(posedge clk) disable iff (rst)
        att_in.vld |=>
            s_ff.euler_rp == {$past(att_in.roll), $past(att_in.pitch)};
    endproperty
    a_euler_pack: assert property (p_euler_pack)
        else $error("roll and pitch not packed after update");

    property p_yaw_resv;
        @(posedge clk) disable iff (rst)
        att_in.vld |=> (s_ff.yaw[31:16] == $past(att_in.yaw)) &&
                       (s_ff.yaw[15:0] == `AGR_RESV_HALF);
    endproperty
    a_yaw_resv: assert property (p_yaw_resv)
        else $error("yaw word not packed with zero low half");

    property p_quat_pack;
        @(posedge clk) disable iff (rst)
        (att_in.vld && quat_mode) |=>
            (s_ff.quat_ab == {$past(att_in.qa), $past(att_in.qb)}) &&
            (s_ff.quat_cd == {$past(att_in.qc), $past(att_in.qd)});
    endproperty
    a_quat_pack: assert property (p_quat_pack)
        else $error("quaternion words not packed in quaternion mode");

    property p_quat_hold;
        @(posedge clk) disable iff (rst)
        (att_in.vld && !quat_mode) |=>
            $stable(s_ff.quat_ab) && $stable(s_ff.quat_cd);
    endproperty
    a_quat_hold: assert property (p_quat_hold)
        else $error("quaternion words changed in euler mode");

    property p_cov_zero;
        @(posedge clk) disable iff (rst)
        (cov_in.vld && !quat_mode &&
         ((cov_in.idx[1:0] == 2'h3) || (cov_in.idx[3:2] == 2'h3))) |=>
            s_ff.cov[$past(cov_in.idx)] == `AGR_WORD_RST;
    endproperty
    a_cov_zero: assert property (p_cov_zero)
        else $error("fourth covariance row or column not zero");

    property p_cov_read;
        @(posedge clk) disable iff (rst)
        (rd_req.en && (rd_req.addr == `AGR_OFS_COV_FIRST + 8'h05)) |=>
            rd_rsp.ack && !rd_rsp.miss &&
            (rd_rsp.data == $past(s_ff.cov[5]));
    endproperty
    a_cov_read: assert property (p_cov_read)
        else $error("row two column two not read from 0x6b");

    property p_gps_gate;
        @(posedge clk) disable iff (rst)
        (!gps_present && (pos_in.vld || rel_in.vld)) |=>
            $stable(s_ff.lon) && $stable(s_ff.rel_n);
    endproperty
    a_gps_gate: assert property (p_gps_gate)
        else $error("position changed without a receiver");

    property p_vtg_pack;
        @(posedge clk) disable iff (rst)
        (gps_present && vtg_in.vld) |=>
            s_ff.crs_spd == {$past(vtg_in.course), $past(vtg_in.speed)};
    endproperty
    a_vtg_pack: assert property (p_vtg_pack)
        else $error("course and speed not packed after update");

    property p_temp_out;
        @(posedge clk) disable iff (rst)
        temp_in.vld |=> (gyro_temp == $past(temp_in.val)) ##1
            (rd_rsp.data == gyro_temp) || !$past(rd_req.en) ||
            ($past(rd_req.addr) != `AGR_OFS_TEMP);
    endproperty
    a_temp_out: assert property (p_temp_out)
        else $error("temperature not forwarded to compensation");

    property p_whole_read;
        @(posedge clk) disable iff (rst)
        rd_req.en |=> rd_rsp.ack &&
            (rd_rsp.data == agr_read($past(s_ff), $past(rd_req.addr))) &&
            (rd_rsp.miss == !agr_hit($past(rd_req.addr)));
    endproperty
    a_whole_read: assert property (p_whole_read)
        else $error("read answer not the whole settled word");

    property p_ack_pulse;
        @(posedge clk) disable iff (rst)
        !rd_req.en |=> !rd_rsp.ack;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("read acknowledge without a request");

    property p_pos_pack;
        @(posedge clk) disable iff (rst)
        (gps_present && pos_in.vld) |=> {s_ff.lon, s_ff.lat, s_ff.alt}
            == $past({pos_in.a, pos_in.b, pos_in.c});
    endproperty
    a_pos_pack: assert property (p_pos_pack)
        else $error("position words not stored with a receiver");

    property p_rel_pack;
        @(posedge clk) disable iff (rst)
        (gps_present && rel_in.vld) |=> {s_ff.rel_n, s_ff.rel_e, s_ff.rel_h}
            == $past({rel_in.a, rel_in.b, rel_in.c});
    endproperty
    a_rel_pack: assert property (p_rel_pack)
        else $error("home-relative words not stored with a receiver");

    property p_vtg_gate;
        @(posedge clk) disable iff (rst)
        (!gps_present && vtg_in.vld) |=> $stable(s_ff.crs_spd);
    endproperty
    a_vtg_gate: assert property (p_vtg_gate)
        else $error("course and speed changed without a receiver");

    property p_cov_store;
        @(posedge clk) disable iff (rst)
        (cov_in.vld && quat_mode) |=>
            s_ff.cov[$past(cov_in.idx)] == $past(cov_in.val);
    endproperty
    a_cov_store: assert property (p_cov_store)
        else $error("covariance cell not stored in quaternion mode");

    property p_miss_read;
        @(posedge clk) disable iff (rst)
        (rd_req.en && (rd_req.addr > `AGR_OFS_CRS_SPD)) |=>
            rd_rsp.miss && (rd_rsp.data == `AGR_WORD_RST);
    endproperty
    a_miss_read: assert property (p_miss_read)
        else $error("read above the bank not answered as a miss");

    property p_magz_hold;
        @(posedge clk) disable iff (rst)
        !magz.vld |=> $stable(s_ff.magz);
    endproperty
    a_magz_hold: assert property (p_magz_hold)
        else $error("processed z word changed without a result");

    property p_euler_hold;
        @(posedge clk) disable iff (rst)
        !att_in.vld |=> $stable(s_ff.euler_rp) && $stable(s_ff.yaw);
    endproperty
    a_euler_hold: assert property (p_euler_hold)
        else $error("euler words changed without an update");

endmodule // agr_regs

`default_nettype wire

//--- agr_map.svh
// Offsets, field positions, reset values and scale figures of the bank
`ifndef AGR_MAP_SVH
`define AGR_MAP_SVH

// Word offsets as seen by the serial register interface
`define AGR_OFS_MAGZ      8'h61
`define AGR_OFS_EULER_RP  8'h62
`define AGR_OFS_YAW       8'h63
`define AGR_OFS_QUAT_AB   8'h64
`define AGR_OFS_QUAT_CD   8'h65
`define AGR_OFS_COV_FIRST 8'h66
`define AGR_OFS_COV_LAST  8'h75
`define AGR_OFS_TEMP      8'h76
`define AGR_OFS_LON       8'h77
`define AGR_OFS_LAT       8'h78
`define AGR_OFS_ALT       8'h79
`define AGR_OFS_REL_N     8'h7a
`define AGR_OFS_REL_E     8'h7b
`define AGR_OFS_REL_H     8'h7c
`define AGR_OFS_CRS_SPD   8'h7d

// Half-word field positions inside a 32-bit word
`define AGR_HI_MSB 31
`define AGR_HI_LSB 16
`define AGR_LO_MSB 15
`define AGR_LO_LSB 0

// Reset and reserved values
`define AGR_RESV_HALF 16'h0000
`define AGR_WORD_RST  32'h0000_0000

// Fraction bits of the magnetometer calibration coefficients
`define AGR_MAG_FRAC 14

// Scale of one count: billionths of the unit, trillionths for the quaternion, a divisor for course and speed
`define AGR_MAG_LSB_NANO  305176
`define AGR_ANG_LSB_NANO  10986300
`define AGR_QUAT_LSB_PICO 33569300
`define AGR_GND_DIV       100

// Cycles from a read request to its answer
`define AGR_RD_LAT 1

`endif

//--- agr_pkg.sv
// Types shared by the attitude and GPS output register bank
`default_nettype none
package agr_pkg;

    typedef logic signed [15:0] agr_s16_t;

    // Three axes, index 0 = x, 1 = y, 2 = z
    typedef logic [2:0][15:0] agr_vec3_t;

    typedef struct packed {
        logic      vld;
        agr_vec3_t raw;
        agr_vec3_t bias;
        agr_vec3_t cal_row_z;
    } agr_mag_in_t;

    typedef struct packed {
        logic     vld;
        agr_s16_t roll;
        agr_s16_t pitch;
        agr_s16_t yaw;
        agr_s16_t qa;
        agr_s16_t qb;
        agr_s16_t qc;
        agr_s16_t qd;
    } agr_att_in_t;

    typedef struct packed {
        logic        vld;
        logic [3:0]  idx;
        logic [31:0] val;
    } agr_cov_in_t;

    typedef struct packed {
        logic        vld;
        logic [31:0] val;
    } agr_word_in_t;

    typedef struct packed {
        logic        vld;
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] c;
    } agr_trio_in_t;

    typedef struct packed {
        logic        vld;
        agr_s16_t    course;
        logic [15:0] speed;
    } agr_vtg_in_t;

    typedef struct packed {
        logic       en;
        logic [7:0] addr;
    } agr_rd_req_t;

    typedef struct packed {
        logic        ack;
        logic        miss;
        logic [31:0] data;
    } agr_rd_rsp_t;

    // Processed Z result, also the whole state of the calculator
    typedef struct packed {
        logic     vld;
        agr_s16_t val;
    } agr_magz_t;

    // Whole state of the register bank
    typedef struct packed {
        logic [31:0]       magz;
        logic [31:0]       euler_rp;
        logic [31:0]       yaw;
        logic [31:0]       quat_ab;
        logic [31:0]       quat_cd;
        logic [15:0][31:0] cov;
        logic [31:0]       temp;
        logic [31:0]       lon;
        logic [31:0]       lat;
        logic [31:0]       alt;
        logic [31:0]       rel_n;
        logic [31:0]       rel_e;
        logic [31:0]       rel_h;
        logic [31:0]       crs_spd;
        agr_rd_rsp_t       rsp;
    } agr_bank_t;

endpackage

`default_nettype wire

//--- agr_magz.sv
// Processed Z magnetometer calculator: calibration row applied to raw data
`timescale 1ns/1ps
`default_nettype none
`include "agr_map.svh"

module agr_magz (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rst,
    // Raw sample with offsets and calibration row
    input  wire agr_pkg::agr_mag_in_t mag_in,
    // Result, one cycle after the sample
    output agr_pkg::agr_magz_t       magz_out
);
    import agr_pkg::*;

    localparam logic signed [34:0] MAX_V = 35'sh7fff;
    localparam logic signed [34:0] MIN_V = -35'sh8000;

    logic signed [16:0] dif [3];
    logic signed [32:0] prd [3];
    logic signed [34:0] sum;
    logic signed [34:0] shf;
    agr_magz_t          s_ff;
    agr_magz_t          nxt;

    // -------------------------------------------------------------
    // Offset removal and calibration products
    // -------------------------------------------------------------
    genvar i;
    for (i = 0; i < 3; i++) begin : g_axis
        assign dif[i] = $signed({mag_in.raw[i][15], mag_in.raw[i]})
                      - $signed({mag_in.bias[i][15], mag_in.bias[i]});
        assign prd[i] = dif[i] * $signed(mag_in.cal_row_z[i]);
    end

    // calibration row sums the three axes
    assign sum = 35'(prd[0]) + 35'(prd[1]) + 35'(prd[2]);
    assign shf = sum >>> `AGR_MAG_FRAC;

    // Saturation keeps a wild sample from wrapping sign
    always_comb begin
        nxt     = s_ff;
        nxt.vld = mag_in.vld;
        if (mag_in.vld) begin
            // result counted in unit-norm field steps
            if (shf > MAX_V) begin
                nxt.val = 16'sh7fff;
            end else if (shf < MIN_V) begin
                nxt.val = -16'sh8000;
            end else begin
                nxt.val = shf[15:0];
            end
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt;
        end
    end

    assign magz_out = s_ff;

    property p_magz_lat;
        @(posedge clk) disable iff (rst)
        mag_in.vld |=> magz_out.vld;
    endproperty
    a_magz_lat: assert property (p_magz_lat)
        else $error("processed z not produced one cycle after sample");

endmodule // agr_magz

`default_nettype wire

//--- agr_host.sv
// Host model that reads the output bank through the word read port
`timescale 1ns/1ps
`default_nettype none

module agr_host (
    // Clock
    input  wire logic                 clk,
    // Read port
    output var agr_pkg::agr_rd_req_t  rd_req,
    input  wire agr_pkg::agr_rd_rsp_t rd_rsp
);
    import agr_pkg::*;

    // ----------------------------------------------------------------
    // Read sequencing
    // ----------------------------------------------------------------
    // Idle port from time zero
    initial begin
        rd_req = '0;
    end

    // whole word read
    // One strobe cycle, then a bounded wait for the answer. The released
    // address shows its inverse, so a stale value can never pass.
    task automatic read(input logic [7:0] a, output logic [31:0] d,
                        output logic m, output logic ok);
        ok = 1'b0;
        d  = '0;
        m  = 1'b0;
        @(posedge clk);
        rd_req <= '{en: 1'b1, addr: a};
        @(posedge clk);
        rd_req <= '{en: 1'b0, addr: ~a};
        for (int i = 0; i < 4 && !ok; i++) begin
            @(posedge clk);
            if (rd_rsp.ack === 1'b1) begin
                d  = rd_rsp.data;
                m  = rd_rsp.miss;
                ok = 1'b1;
            end
        end
    endtask
endmodule // agr_host
`default_nettype wire

//--- test_attitude_gps_output_regs.sv
// Self-checking testbench of the attitude and GPS output register bank
`timescale 1ns/1ps
`default_nettype none

module test_attitude_gps_output_regs;
    import agr_pkg::*;

    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic         clk;
    logic         rst;
    logic         quat_mode;
    logic         gps_present;
    agr_mag_in_t  mag_in;
    agr_att_in_t  att_in;
    agr_cov_in_t  cov_in;
    agr_word_in_t temp_in;
    agr_trio_in_t pos_in;
    agr_trio_in_t rel_in;
    agr_vtg_in_t  vtg_in;
    agr_rd_req_t  rd_req;
    agr_rd_rsp_t  rd_rsp;
    logic [31:0]  gyro_temp;
    int           n_fail;
    int           n_compared;

    agr_regs dut_u (.clk(clk), .rst(rst), .quat_mode(quat_mode),
        .gps_present(gps_present), .mag_in(mag_in), .att_in(att_in),
        .cov_in(cov_in), .temp_in(temp_in), .pos_in(pos_in),
        .rel_in(rel_in), .vtg_in(vtg_in), .rd_req(rd_req),
        .rd_rsp(rd_rsp), .gyro_temp(gyro_temp));

    agr_host host_u (.clk(clk), .rd_req(rd_req), .rd_rsp(rd_rsp));

    // 100 MHz clock
    always #5 clk = ~clk;

    // ----------------------------------------------------------------
    // Compare and report
    // ----------------------------------------------------------------
    task automatic test_done();
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk32(string name, logic [31:0] e, logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", name, e, g);
        end
    endtask

    task automatic chk1(string name, logic e, logic g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s: expected %b, seen %b", name, e, g);
        end
    endtask

    // Read a word and judge data and miss; a lost answer ends the run
    task automatic rd(logic [7:0] a, logic [31:0] e, logic me);
        logic [31:0] d;
        logic        m;
        logic        ok;
        host_u.read(a, d, m, ok);
        chk1("read answer", 1'b1, ok);
        if (!ok) begin
            test_done();
        end
        chk32("read data", e, d);
        chk1("miss flag", me, m);
    endtask

    // ----------------------------------------------------------------
    // Update drivers
    // ----------------------------------------------------------------
    task automatic att_put(logic qm, logic [6:0][15:0] v);
        @(posedge clk);
        quat_mode <= qm;
        att_in    <= {1'b1, v};
        @(posedge clk);
        att_in.vld <= 1'b0;
    endtask

    task automatic gps_put(logic gp, logic [31:0] b);
        logic [31:0] b6;
        b6 = b + 32'h6;
        @(posedge clk);
        gps_present <= gp;
        pos_in <= '{1'b1, b, b + 32'h1, b + 32'h2};
        rel_in <= '{1'b1, b + 32'h3, b + 32'h4, b + 32'h5};
        vtg_in <= '{1'b1, b6[31:16], b6[15:0]};
        @(posedge clk);
        pos_in.vld <= 1'b0;
        rel_in.vld <= 1'b0;
        vtg_in.vld <= 1'b0;
    endtask

    // Expected processed Z word, worked out with plain integers
    function automatic logic [31:0] magz_word(agr_vec3_t r, agr_vec3_t b,
                                              agr_vec3_t c);
        int s = 0;
        int q;
        for (int i = 0; i < 3; i++) begin
            s += (int'($signed(r[i])) - int'($signed(b[i])))
                 * int'($signed(c[i]));
        end
        q = s >>> 14;
        q = (q > 32767) ? 32767 : ((q < -32768) ? -32768 : q);
        return {q[15:0], 16'h0000};
    endfunction

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        for (int a = 8'h61; a <= 8'h7d; a++) begin
            rd(8'(a), 32'h0, 1'b0);
        end
        rd(8'h60, 32'h0, 1'b1);
        rd(8'h7e, 32'h0, 1'b1);
    endtask

    task automatic t_attitude();
        att_put(1'b1, {16'h8001, 16'h7fff, 16'h1234, 16'h7000,
                       16'hc000, 16'h0001, 16'hffff});
        rd(8'h62, 32'h8001_7fff, 1'b0);
        rd(8'h63, 32'h1234_0000, 1'b0);
        rd(8'h64, 32'h7000_c000, 1'b0);
        rd(8'h65, 32'h0001_ffff, 1'b0);
        // Euler mode: angles move on, quaternion words keep old value
        att_put(1'b0, {16'h0100, 16'hfe00, 16'hedcb, {4{16'h1111}}});
        rd(8'h62, 32'h0100_fe00, 1'b0);
        rd(8'h63, 32'hedcb_0000, 1'b0);
        rd(8'h64, 32'h7000_c000, 1'b0);
        rd(8'h65, 32'h0001_ffff, 1'b0);
    endtask

    // A read taken with an update returns the old word, never a mix
    task automatic t_atomic();
        fork
            rd(8'h62, 32'h0100_fe00, 1'b0);
            att_put(1'b1, {16'h5a5a, 16'ha5a5, 16'h0f0f, {4{16'h2222}}});
        join
        rd(8'h62, 32'h5a5a_a5a5, 1'b0);
    endtask

    task automatic t_cov();
        logic [31:0] v;
        for (int q = 1; q >= 0; q--) begin
            for (int i = 0; i < 16; i++) begin
                @(posedge clk);
                quat_mode <= q[0];
                cov_in <= '{1'b1, 4'(i), 32'h3f80_0000 + 32'(i + q * 16)};
            end
            @(posedge clk);
            cov_in.vld <= 1'b0;
            for (int i = 0; i < 16; i++) begin
                v = 32'h3f80_0000 + 32'(i + q * 16);
                if (q == 0 && (i % 4 == 3 || i / 4 == 3)) begin
                    v = 32'h0;
                end
                rd(8'h66 + 8'(i), v, 1'b0);
            end
        end
    endtask

    task automatic t_temp();
        @(posedge clk);
        temp_in <= '{1'b1, 32'h41c8_0000};
        @(posedge clk);
        temp_in.vld <= 1'b0;
        rd(8'h76, 32'h41c8_0000, 1'b0);
        chk32("gyro temp", 32'h41c8_0000, gyro_temp);
    endtask

    // Course ee6c is negative, speed fde6 has its top bit set
    task automatic t_gps();
        gps_put(1'b1, 32'hee6c_fde0);
        for (int k = 0; k < 7; k++) begin
            rd(8'h77 + 8'(k), 32'hee6c_fde0 + 32'(k), 1'b0);
        end
        gps_put(1'b0, 32'h4000_0010);
        for (int k = 0; k < 7; k++) begin
            rd(8'h77 + 8'(k), 32'hee6c_fde0 + 32'(k), 1'b0);
        end
    endtask

    task automatic t_mag(agr_vec3_t r, agr_vec3_t b, agr_vec3_t c);
        @(posedge clk);
        mag_in <= '{1'b1, r, b, c};
        @(posedge clk);
        mag_in.vld <= 1'b0;
        repeat (2) @(posedge clk);
        rd(8'h61, magz_word(r, b, c), 1'b0);
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        quat_mode = 1'b0;
        gps_present = 1'b0;
        {mag_in, att_in, cov_in, temp_in} = '0;
        {pos_in, rel_in, vtg_in} = '0;
        n_fail = 0;
        n_compared = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_attitude();
        t_atomic();
        t_cov();
        t_temp();
        t_gps();
        t_mag({16'd1000, 16'd50, 16'd100}, {16'd200, 16'd20, 16'd10},
              {16'h4000, 16'h2000, 16'hc000});
        t_mag({16'd20000, 16'd0, 16'd0}, '0,
              {16'h7fff, 16'h0000, 16'h0000});
        t_mag({16'd20000, 16'd0, 16'd0}, '0,
              {16'h8000, 16'h0000, 16'h0000});
        test_done();
    end
endmodule // test_attitude_gps_output_regs
`default_nettype wire
